/* File: pkg/prbs_loopback_pkg.sv */
// Shared constants, types and register map of the loopback test engine
package prbs_loopback_pkg;

    // ****************************************
    // Sizes and timing
    // ****************************************
    localparam int NUM_LANES = 6;                  // Lanes behind the engine
    localparam int WORD_W = 32;                    // Parallel word width
    localparam int ADDR_W = 8;                     // APB address width
    localparam int CLK_MHZ = 100;                  // pclk rate in MHz
    localparam int WINDOW_US = 1000;               // Measurement window in us
    localparam int WINDOW_CYCLES = WINDOW_US * CLK_MHZ;
    localparam int BYTES_PER_WORD = WORD_W / 8;
    localparam int SYNC_WORDS = 4;                 // Clean words to gain sync
    localparam int LOSS_WORDS = 4;                 // Bad words to drop sync
    localparam int LF_PERIOD = 33;                 // Low-frequency period, bits
    localparam int LF_HIGH = 17;                   // Bits high per period

    // ****************************************
    // Register offsets (byte addresses)
    // ****************************************
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CMD = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_DET_ERR = 8'h0C;
    localparam logic [7:0] OFS_INS_ERR = 8'h10;
    localparam logic [7:0] OFS_TX_BPS = 8'h14;
    localparam logic [7:0] OFS_RX_BPS = 8'h18;
    localparam logic [7:0] OFS_UTIL = 8'h1C;
    localparam logic [7:0] OFS_CHAN = 8'h20;       // First of NUM_LANES words

    // ****************************************
    // Field positions and reset values
    // ****************************************
    localparam int CTRL_RUN = 0;
    localparam int CTRL_LPBK = 1;
    localparam int CTRL_PAT = 2;                   // Three bits
    localparam int CTRL_PORT = 5;                  // Three bits
    localparam int CMD_INSERT = 0;
    localparam int CMD_CLEAR = 1;
    localparam int ST_PLL = 0;
    localparam int ST_SYNC = 1;
    localparam int ST_RUN = 2;
    localparam int CHAN_TYPE = 31;
    localparam int UTIL_RX = 8;                    // Rx percent lsb, tx at 0
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] HF_WORD = 32'hAAAA_AAAA;
    localparam logic [31:0] INSERT_MASK = 32'h0000_0001;
    localparam logic [30:0] PRBS_SEED = 31'h7FFF_FFFF;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [2:0] {
        PAT_PRBS7 = 3'h0,
        PAT_PRBS15 = 3'h1,
        PAT_PRBS23 = 3'h2,
        PAT_PRBS31 = 3'h3,
        PAT_HF = 3'h4,
        PAT_LF = 3'h5
    } pattern_t;

    typedef enum logic [1:0] {
        RUN_IDLE = 2'h1,
        RUN_ACTIVE = 2'h2
    } run_state_t;

    typedef struct packed {
        logic valid;
        logic [WORD_W-1:0] data;
    } lane_word_t;

    typedef struct packed {
        logic [WORD_W-1:0] bits;                   // Tx bits or error mask
        logic [30:0] state;
    } prbs_res_t;

endpackage

/* File: src/prbs_loopback_tester.sv */
// Loopback pattern generator, checker and statistics with an APB slave
//
// The implementer's own choices: the APB register port and the register addresses.
`timescale 1ns/1ps

module prbs_loopback_tester #(
    parameter int MEAS_CYCLES = prbs_loopback_pkg::WINDOW_CYCLES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [prbs_loopback_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output prbs_loopback_pkg::lane_word_t tx_word,
    output logic [prbs_loopback_pkg::NUM_LANES-1:0] tx_lane_en,
    output logic serial_loopback,
    input wire prbs_loopback_pkg::lane_word_t [prbs_loopback_pkg::NUM_LANES-1:0] rx_lane,
    input wire logic pll_locked,
    input wire logic [prbs_loopback_pkg::NUM_LANES-1:0] transceiver_lane_type
);
    import prbs_loopback_pkg::*;

    // ****************************************
    // Pattern functions
    // ****************************************

    // Steps a 31-bit LFSR over one word, msb first; gen mode makes data,
    // check mode seeds from received bits and returns the error mask
    function automatic prbs_res_t prbs_step(input logic [30:0] st,
                                            input logic [WORD_W-1:0] din,
                                            input pattern_t pat,
                                            input logic gen);
        prbs_res_t r;
        logic fb;
        logic nb;
        r.state = st;
        r.bits = '0;
        for (int i = WORD_W - 1; i >= 0; i--) begin
            // Maximal-length feedback for each order
            case (pat)
                PAT_PRBS15: fb = r.state[14] ^ r.state[13];
                PAT_PRBS23: fb = r.state[22] ^ r.state[17];
                PAT_PRBS31: fb = r.state[30] ^ r.state[27];
                default: fb = r.state[6] ^ r.state[5];
            endcase
            nb = gen ? fb : din[i];
            r.bits[i] = gen ? fb : (fb ^ din[i]);
            r.state = {r.state[29:0], nb};
        end
        return r;
    endfunction

    // Square wave of 33-bit period, phase counts down one per bit
    function automatic logic [WORD_W-1:0] lf_word(input logic [5:0] ph);
        logic [WORD_W-1:0] w;
        logic [5:0] p;
        w = '0;
        p = ph;
        for (int i = WORD_W - 1; i >= 0; i--) begin
            w[i] = (p < 6'(LF_HIGH));
            p = (p == 6'h00) ? 6'(LF_PERIOD - 1) : p - 6'h01;
        end
        return w;
    endfunction

    // Number of set bits in a word
    function automatic logic [5:0] ones(input logic [WORD_W-1:0] w);
        logic [5:0] n;
        n = '0;
        for (int i = 0; i < WORD_W; i++) begin
            n = n + 6'(w[i]);
        end
        return n;
    endfunction

    // ****************************************
    // Declarations
    // ****************************************
    logic [31:0] ctrl;                    // Run, loopback, pattern, port
    pattern_t pattern;                    // Pattern in force
    logic [2:0] port_sel;                 // Port under test
    logic [NUM_LANES-1:0] port_mask;      // Lanes of that port
    run_state_t run_state;                // Run state machine
    logic running;                        // Run is active
    logic run_q;                          // Last run bit, for start edge
    logic start;                          // Start command seen
    logic wr_en;                          // APB write takes effect
    logic insert_req;                     // Insert command pulse
    logic clear_req;                      // Clear command pulse
    logic insert_pend;                    // Insert awaiting next word
    logic [30:0] gen_st;                  // Generator LFSR
    logic [5:0] lf_phase;                 // Low-frequency phase
    logic [1:0] pll_sync;                 // Lock synchroniser
    logic [NUM_LANES-1:0] type_s1;        // Type synchroniser, stage one
    logic [NUM_LANES-1:0] type_s2;        // Type synchroniser, stage two
    logic checkable;                      // Pattern can be checked
    logic [NUM_LANES-1:0] lane_synced;    // Per-lane sync flags
    logic [5:0] lane_errs [NUM_LANES];    // Per-lane bit errors this cycle
    logic [8:0] next_err_sum;             // All lanes' errors this cycle
    logic all_synced;                     // Every lane of the port synced
    logic [31:0] det_err;                 // Detected error count
    logic [31:0] ins_err;                 // Inserted error count
    logic [31:0] win_cnt;                 // Window cycle counter
    logic win_end;                        // Last cycle of a window
    logic [31:0] tx_words;                // Lane words sent this window
    logic [31:0] rx_words;                // Lane words seen this window
    logic [31:0] tx_cyc;                  // Cycles sending this window
    logic [31:0] rx_cyc;                  // Cycles with full rx this window
    logic [31:0] chan_cnt [NUM_LANES];    // Per-lane words this window
    logic [31:0] chan_mbps [NUM_LANES];   // Per-lane rate in Mbps
    logic [31:0] tx_bps;                  // Tx bytes per second
    logic [31:0] rx_bps;                  // Rx bytes per second
    logic [7:0] tx_util;                  // Tx percent of maximum
    logic [7:0] rx_util;                  // Rx percent of maximum
    logic [3:0] next_tx_n;                // Lanes sending this cycle
    logic [3:0] next_rx_n;                // Lanes receiving this cycle
    logic [31:0] next_rdata;              // Read data for the access
    logic next_slverr;                    // Unmapped address flag
    prbs_res_t gen_res;                   // Generator step result

    // ****************************************
    // Control decode
    // ****************************************

    // Codes outside the list fall back to PRBS7
    always_comb begin
        case (ctrl[CTRL_PAT +: 3])
            3'h1: pattern = PAT_PRBS15;
            3'h2: pattern = PAT_PRBS23;
            3'h3: pattern = PAT_PRBS31;
            3'h4: pattern = PAT_HF;
            3'h5: pattern = PAT_LF;
            default: pattern = PAT_PRBS7;
        endcase
    end

    // Port code 0 is the x4 group, 1 the x6 group, 2 up a single lane
    always_comb begin
        port_sel = ctrl[CTRL_PORT +: 3];
        if (port_sel == 3'h0) begin
            port_mask = 6'h0F;
        end else if (port_sel == 3'h1) begin
            port_mask = 6'h3F;
        end else begin
            port_mask = 6'(6'h01 << (port_sel - 3'h2));
        end
    end

    assign running = (run_state == RUN_ACTIVE);
    assign start = ctrl[CTRL_RUN] & ~run_q;
    assign wr_en = psel & penable & pwrite;
    assign insert_req = wr_en & (paddr == OFS_CMD) & pwdata[CMD_INSERT];
    assign clear_req = wr_en & (paddr == OFS_CMD) & pwdata[CMD_CLEAR];
    assign checkable = (pattern != PAT_HF) && (pattern != PAT_LF);
    assign gen_res = prbs_step(gen_st, '0, pattern, 1'b1);

    // ****************************************
    // APB slave
    // ****************************************

    // Control register, written on the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= CTRL_RESET;
        end else if (wr_en && paddr == OFS_CTRL) begin
            ctrl <= pwdata;
        end
    end

    // Read mux, evaluated while the transfer is in setup
    always_comb begin
        next_rdata = '0;
        next_slverr = 1'b0;
        if (paddr == OFS_CTRL) begin
            next_rdata = {24'h00_0000, ctrl[7:0]};
        end else if (paddr == OFS_CMD) begin
            next_rdata = '0;
        end else if (paddr == OFS_STATUS) begin
            next_rdata[ST_PLL] = pll_sync[1];
            next_rdata[ST_SYNC] = all_synced;
            next_rdata[ST_RUN] = running;
        end else if (paddr == OFS_DET_ERR) begin
            next_rdata = det_err;
        end else if (paddr == OFS_INS_ERR) begin
            next_rdata = ins_err;
        end else if (paddr == OFS_TX_BPS) begin
            next_rdata = tx_bps;
        end else if (paddr == OFS_RX_BPS) begin
            next_rdata = rx_bps;
        end else if (paddr == OFS_UTIL) begin
            next_rdata = {16'h0000, rx_util, tx_util};
        end else if (paddr >= OFS_CHAN && paddr < OFS_CHAN + 8'(4 * NUM_LANES)
                     && paddr[1:0] == 2'h0) begin
            next_rdata = chan_mbps[3'((paddr - OFS_CHAN) >> 2)];
            next_rdata[CHAN_TYPE] = type_s2[3'((paddr - OFS_CHAN) >> 2)];
        end else begin
            next_slverr = 1'b1;
        end
    end

    // Answer registers, ready from the first edge after reset so no wait states
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= 1'b1;
            if (psel && !penable) begin
                prdata <= pwrite ? 32'h0000_0000 : next_rdata;
                pslverr <= next_slverr;
            end
        end
    end

    // ****************************************
    // Run control
    // ****************************************

    // Start edge enters a run; clearing the run bit stops it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_state <= RUN_IDLE;
            run_q <= 1'b0;
        end else begin
            run_q <= ctrl[CTRL_RUN];
            case (run_state)
                RUN_IDLE: begin
                    if (start) begin
                        run_state <= RUN_ACTIVE;
                    end
                end
                RUN_ACTIVE: begin
                    if (!ctrl[CTRL_RUN]) begin
                        run_state <= RUN_IDLE;
                    end
                end
                default: run_state <= RUN_IDLE;
            endcase
        end
    end

    // Lock and lane-type pins from outside pass two flip-flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pll_sync <= 2'h0;
            type_s1 <= '0;
            type_s2 <= '0;
        end else begin
            pll_sync <= {pll_sync[0], pll_locked};
            type_s1 <= transceiver_lane_type;
            type_s2 <= type_s1;
        end
    end

    // ****************************************
    // Generator
    // ****************************************

    // One word per cycle while running; reseeded at every start
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gen_st <= PRBS_SEED;
            lf_phase <= 6'h00;
            tx_word <= '0;
            tx_lane_en <= '0;
            serial_loopback <= 1'b0;
        end else begin
            serial_loopback <= ctrl[CTRL_LPBK];
            tx_lane_en <= running ? port_mask : '0;
            tx_word.valid <= running;
            if (start) begin
                gen_st <= PRBS_SEED;
                lf_phase <= 6'(LF_PERIOD - 1);
            end else if (running) begin
                gen_st <= gen_res.state;
                lf_phase <= 6'((int'(lf_phase) + LF_PERIOD - WORD_W % LF_PERIOD) % LF_PERIOD);
            end
            if (!running) begin
                tx_word.data <= '0;
            end else if (pattern == PAT_HF) begin
                tx_word.data <= HF_WORD;
            end else if (pattern == PAT_LF) begin
                tx_word.data <= lf_word(lf_phase);
            end else begin
                // A pending insert flips one bit of this word only
                tx_word.data <= gen_res.bits ^ (insert_pend ? INSERT_MASK : '0);
            end
        end
    end

    // Insert is held until the next word goes out, only during a run
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            insert_pend <= 1'b0;
        end else if (!running) begin
            insert_pend <= 1'b0;
        end else begin
            insert_pend <= insert_req;
        end
    end

    // ****************************************
    // Checkers, one per lane
    // ****************************************
    for (genvar g = 0; g < NUM_LANES; g++) begin : g_chk
        logic [30:0] st;         // Receive LFSR
        logic [2:0] good;        // Clean words in a row
        logic [2:0] bad;         // Errored words in a row
        prbs_res_t res;          // Check result
        logic act;               // Lane checked this cycle
        assign res = prbs_step(st, rx_lane[g].data, pattern, 1'b0);
        assign act = running & port_mask[g] & checkable & rx_lane[g].valid;
        assign lane_errs[g] = (act && lane_synced[g]) ? ones(res.bits) : 6'h00;

        // Seed from the stream, then gain and lose sync on word counts
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                st <= '0;
                good <= '0;
                bad <= '0;
                lane_synced[g] <= 1'b0;
            end else if (!running || !port_mask[g] || !checkable) begin
                good <= '0;
                bad <= '0;
                lane_synced[g] <= 1'b0;
            end else if (act) begin
                st <= res.state;
                if (!lane_synced[g]) begin
                    good <= (res.bits == '0) ? good + 3'h1 : 3'h0;
                    if (res.bits == '0 && good == 3'(SYNC_WORDS - 1)) begin
                        lane_synced[g] <= 1'b1;
                        bad <= '0;
                    end
                end else if (res.bits != '0) begin
                    bad <= bad + 3'h1;
                    if (bad == 3'(LOSS_WORDS - 1)) begin
                        lane_synced[g] <= 1'b0;
                        good <= '0;
                    end
                end else begin
                    bad <= '0;
                end
            end
        end
    end

    // Sum of errors and lane counts across the port
    always_comb begin
        next_err_sum = '0;
        next_tx_n = '0;
        next_rx_n = '0;
        for (int i = 0; i < NUM_LANES; i++) begin
            next_err_sum = next_err_sum + 9'(lane_errs[i]);
            next_tx_n = next_tx_n + 4'(port_mask[i] & running);
            next_rx_n = next_rx_n + 4'(port_mask[i] & running & rx_lane[i].valid);
        end
    end

    assign all_synced = running && ((lane_synced & port_mask) == port_mask);

    // ****************************************
    // Error counters
    // ****************************************

    // Saturating; a clear keeps an error of the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            det_err <= '0;
            ins_err <= '0;
        end else begin
            if (clear_req) begin
                det_err <= 32'(next_err_sum);
                ins_err <= 32'(insert_pend);
            end else begin
                if ({1'b0, det_err} + 33'(next_err_sum) > 33'hFFFF_FFFF) begin
                    det_err <= 32'hFFFF_FFFF;
                end else begin
                    det_err <= det_err + 32'(next_err_sum);
                end
                if (insert_pend && ins_err != 32'hFFFF_FFFF) begin
                    ins_err <= ins_err + 32'h0000_0001;
                end
            end
        end
    end

    // ****************************************
    // Throughput and rate measurement
    // ****************************************
    assign win_end = (win_cnt == 32'(MEAS_CYCLES - 1));

    // Window counters and latched figures at each window end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            win_cnt <= '0;
            tx_words <= '0;
            rx_words <= '0;
            tx_cyc <= '0;
            rx_cyc <= '0;
            tx_bps <= '0;
            rx_bps <= '0;
            tx_util <= '0;
            rx_util <= '0;
        end else if (win_end) begin
            // Closing cycle counts too, so a full window reads 100 percent
            win_cnt <= '0;
            tx_words <= '0;
            rx_words <= '0;
            tx_cyc <= '0;
            rx_cyc <= '0;
            tx_bps <= 32'((64'(tx_words) + 64'(next_tx_n)) * BYTES_PER_WORD * 1000000
                / WINDOW_US);
            rx_bps <= 32'((64'(rx_words) + 64'(next_rx_n)) * BYTES_PER_WORD * 1000000
                / WINDOW_US);
            tx_util <= 8'((64'(tx_cyc) + 64'(running)) * 100 / MEAS_CYCLES);
            rx_util <= 8'((64'(rx_cyc) + 64'(running && next_rx_n == next_tx_n)) * 100
                / MEAS_CYCLES);
        end else begin
            win_cnt <= win_cnt + 32'h0000_0001;
            tx_words <= tx_words + 32'(next_tx_n);
            rx_words <= rx_words + 32'(next_rx_n);
            tx_cyc <= tx_cyc + 32'(running);
            rx_cyc <= rx_cyc + 32'(running && next_rx_n == next_tx_n);
        end
    end

    // Per-channel words per window, turned into Mbps
    for (genvar c = 0; c < NUM_LANES; c++) begin : g_rate
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                chan_cnt[c] <= '0;
                chan_mbps[c] <= '0;
            end else if (win_end) begin
                chan_cnt[c] <= '0;
                chan_mbps[c] <= 32'((64'(chan_cnt[c]) + 64'(rx_lane[c].valid)) * WORD_W
                    / WINDOW_US);
            end else begin
                chan_cnt[c] <= chan_cnt[c] + 32'(rx_lane[c].valid);
            end
        end
    end

endmodule

/* File: verification/lb_chk_assertions.sv */
// Checker: port-level properties of the loopback engine
`timescale 1ns/1ps
module lb_chk import prbs_loopback_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire prbs_loopback_pkg::lane_word_t tx_word,
    input wire logic [5:0] tx_lane_en,
    input wire logic serial_loopback,
    input wire logic pll_locked
);
    logic [7:0] c, c1, c2; // Shadow of CTRL and two older copies
    wire rd = psel && penable && !pwrite;
    wire st = c == c1 && c1 == c2; // CTRL unchanged for two edges
    wire [2:0] pt = c[4:2];
    wire [2:0] po = c[7:5];
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Track host writes to CTRL
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {c2, c1, c} <= '0;
        end else begin
            {c2, c1} <= {c1, c};
            if (psel && penable && pwrite && paddr == OFS_CTRL) c <= pwdata[7:0];
        end
    end
    chk_hf_word: assert property (tx_word.valid && st && pt == PAT_HF
        |-> tx_word.data[31:1] == HF_WORD[31:1]) else $error("toggle word wrong");
    chk_run_start: assert property ($rose(c[0]) |-> ##[1:3] tx_word.valid)
        else $error("run did not start");
    chk_run_stop: assert property ($fell(c[0])
        |-> ##[1:3] !tx_word.valid && tx_lane_en == 6'h0) else $error("run did not stop");
    chk_idle_quiet: assert property (!c[0] && st
        |-> !tx_word.valid && tx_lane_en == 6'h0) else $error("traffic while idle");
    chk_port_mask: assert property (tx_word.valid && st |-> tx_lane_en ==
        (po == 3'h0 ? 6'h0F : po == 3'h1 ? 6'h3F : 6'h01 << (po - 3'h2)))
        else $error("lane mask wrong");
    chk_loop_copy: assert property (st |-> serial_loopback == c[1])
        else $error("loopback setting wrong");
    chk_pll_read: assert property ($stable(pll_locked)[*6] ##0 rd && paddr == OFS_STATUS
        |-> prdata[ST_PLL] == pll_locked) else $error("lock status wrong");
    chk_no_sync: assert property (rd && paddr == OFS_STATUS && st
        && (pt == PAT_HF || pt == PAT_LF) |-> !prdata[ST_SYNC]) else $error("sync on toggle");
endmodule
bind prbs_loopback_tester lb_chk chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .tx_word(tx_word), .tx_lane_en(tx_lane_en), .serial_loopback(serial_loopback),
    .pll_locked(pll_locked));

/* File: verification/lane_loop.sv */
// Partner: lanes looped back, one cycle of delay
`timescale 1ns/1ps
module lane_loop import prbs_loopback_pkg::*; (
    input wire logic pclk,
    input wire logic presetn,
    input wire prbs_loopback_pkg::lane_word_t tx_word,
    input wire logic [5:0] tx_lane_en,
    output prbs_loopback_pkg::lane_word_t [5:0] rx_lane
);
    // Enabled lanes echo the word; idle lanes show changing junk
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) rx_lane <= '0;
        else for (int i = 0; i < NUM_LANES; i++) begin
            rx_lane[i].valid <= tx_word.valid && tx_lane_en[i];
            rx_lane[i].data <= tx_lane_en[i] ? tx_word.data : ~rx_lane[i].data;
        end
    end
endmodule

/* File: verification/prbs_loopback_tester_bench.sv */
// Testbench: loopback engine with lane loop partner
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fail_count++; \
    $display("MISMATCH %0t %h %h", $time, (g), (e)); end end
module prbs_loopback_tester_bench import prbs_loopback_pkg::*;;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pll_locked = 1;
    logic [7:0] paddr = 8'h0;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic pready, pslverr, serial_loopback;
    lane_word_t tx_word;
    lane_word_t [5:0] rx_lane;
    logic [5:0] tx_lane_en;
    int fail_count = 0, compares = 0, ones;
    typedef struct {logic [7:0] a; logic [31:0] m, e;} row_t;
    // Reset reads: address, mask, expected
    row_t rows[6] = '{'{OFS_CTRL, 32'hFF, 32'h0}, '{OFS_CMD, 32'hFFFF_FFFF, 32'h0},
        '{OFS_DET_ERR, 32'hFFFF_FFFF, 32'h0}, '{OFS_INS_ERR, 32'hFFFF_FFFF, 32'h0},
        '{OFS_CHAN, 32'h8000_0000, 32'h0}, '{8'h24, 32'h8000_0000, 32'h8000_0000}};
    prbs_loopback_tester #(.MEAS_CYCLES(100)) dut_u (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_word(tx_word),
        .tx_lane_en(tx_lane_en), .serial_loopback(serial_loopback), .rx_lane(rx_lane),
        .pll_locked(pll_locked), .transceiver_lane_type(6'h2A));
    lane_loop loop_u (.pclk(pclk), .presetn(presetn), .tx_word(tx_word),
        .tx_lane_en(tx_lane_en), .rx_lane(rx_lane));
    always #5 pclk = ~pclk;
    task automatic finish_test;
        if (fail_count == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // One APB transfer, then an idle edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        int n;
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        n = 0;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin fail_count++; finish_test(); end
        q = prdata;
        psel <= 0;
        penable <= 0;
        @(posedge pclk);
    endtask
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        foreach (rows[i]) begin
            apb(0, rows[i].a, 0, r);
            `CHK(r & rows[i].m, rows[i].e)
        end
        // Each random sequence on lane 0: sync, one insert, figures
        for (int p = 0; p < 4; p++) begin
            apb(1, OFS_CMD, 32'h2, r);
            apb(1, OFS_CTRL, 32'h41 | (p << 2), r);
            for (int n = 0; n < 40 && r[ST_SYNC] !== 1'b1; n++) apb(0, OFS_STATUS, 0, r);
            `CHK(r[ST_SYNC], 1'b1)
            if (r[ST_SYNC] !== 1'b1) finish_test();
            apb(1, OFS_CMD, 32'h1, r);
            repeat (260) @(posedge pclk);
            apb(0, OFS_INS_ERR, 0, r);
            `CHK(r, 32'h1)
            apb(0, OFS_DET_ERR, 0, r);
            `CHK(r, 32'h3)
            apb(0, OFS_UTIL, 0, r);
            `CHK(r[15:0], 16'h6464)
            apb(0, OFS_TX_BPS, 0, r);
            `CHK(r, 100 * BYTES_PER_WORD * 1000000 / WINDOW_US)
            apb(1, OFS_CTRL, 32'h0, r);
        end
        apb(1, OFS_CMD, 32'h1, r);
        apb(0, OFS_INS_ERR, 0, r);
        `CHK(r, 32'h1)
        apb(1, OFS_CMD, 32'h2, r);
        apb(0, OFS_DET_ERR, 0, r);
        `CHK(r, 32'h0)
        apb(0, OFS_INS_ERR, 0, r);
        `CHK(r, 32'h0)
        // Toggle pattern with loopback, then the slow square pattern
        apb(1, OFS_CTRL, 32'h13, r);
        @(posedge pclk);
        `CHK(serial_loopback, 1'b1)
        apb(0, OFS_STATUS, 0, r);
        `CHK(r[ST_SYNC], 1'b0)
        apb(1, OFS_CTRL, 32'h0, r);
        apb(1, OFS_CTRL, 32'h15, r);
        // Every bit of the first 33 words against a 16-low, 17-high square
        ones = 0;
        @(negedge pclk);
        for (int k = 0; k < LF_PERIOD * 32; k += 32) begin
            @(negedge pclk);
            for (int i = 0; i < 32; i++) begin
                ones += (tx_word.data[31 - i] !== ((k + i) % LF_PERIOD >= LF_PERIOD - LF_HIGH));
            end
        end
        `CHK(ones, 0)
        @(posedge pclk);
        pll_locked <= 0;
        repeat (8) @(posedge pclk);
        apb(0, OFS_STATUS, 0, r);
        `CHK(r[ST_PLL], 1'b0)
        finish_test();
    end
endmodule
